// ==== design/char_lcd_pkg.sv ====
package char_lcd_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int EXEC_TIME_NS  = 18500;
  localparam int LONG_TIME_NS  = 760000;
  // Longest execution times round down to whole cycles
  localparam int EXEC_CYCLES   = EXEC_TIME_NS / CLK_PERIOD_NS;
  localparam int LONG_CYCLES   = LONG_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W         = 18;

  // ****************************************************************
  // Command field positions
  // ****************************************************************
  localparam int FS_DL_BIT = 4;
  localparam int FS_N_BIT  = 3;
  localparam int FS_F_BIT  = 2;
  localparam int SH_SC_BIT = 3;
  localparam int SH_RL_BIT = 2;
  localparam int DC_D_BIT  = 2;
  localparam int DC_C_BIT  = 1;
  localparam int DC_B_BIT  = 0;
  localparam int EM_ID_BIT = 1;
  localparam int EM_S_BIT  = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_BUS8   = 1'b1;
  localparam logic RST_TWO    = 1'b0;
  localparam logic RST_FONT   = 1'b0;
  localparam logic RST_DISP   = 1'b0;
  localparam logic RST_CURSOR = 1'b0;
  localparam logic RST_BLINK  = 1'b0;
  localparam logic RST_INC    = 1'b1;
  localparam logic RST_SHIFT  = 1'b0;

  // ****************************************************************
  // Address map of the character RAM
  // ****************************************************************
  localparam logic [6:0] ONE_LINE_END = 7'h4f;
  localparam logic [6:0] LINE1_END    = 7'h27;
  localparam logic [6:0] LINE2_START  = 7'h40;
  localparam logic [6:0] LINE2_END    = 7'h67;
  localparam logic [6:0] ADDR_MAX     = 7'h7f;
  localparam logic [7:0] SPACE_CODE   = 8'h20;
  localparam int CHAR_DEPTH  = 128;
  localparam int GLYPH_DEPTH = 64;

  // ****************************************************************
  // Multiplex duty codes
  // ****************************************************************
  localparam logic [1:0] DUTY_1_8  = 2'h0;
  localparam logic [1:0] DUTY_1_11 = 2'h1;
  localparam logic [1:0] DUTY_1_16 = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_FILL = 2'h3
  } state_t;

endpackage

// ==== design/char_lcd_instruction_port.sv ====
// What this block does
// - Bus-width bit selects byte or nibble transfers
// - Nibble mode: upper lines, high nibble first
// - Nibble mode: busy only after second nibble
// - Line-count bit selects one or two lines
// - Font bit only in one-line; duty follows
// - Command 01: six-bit glyph address loaded
// - Command 1: seven-bit character address loaded
// - One-line character addresses run 00H to 4FH
// - Two-line: 00H-27H and 40H-67H
// - Status read gives busy and address
// - Data write stores into selected RAM
// - Address steps after each RAM write
// - Read without address set returns invalid byte
// - Consecutive reads correct from the second
// - Cursor shift prefetches character RAM data
// - Address steps after each RAM read
// - Read after write returns the byte just written
// - Commands and data latched in holding registers
// - Byte mode: one transfer on eight lines
// - Power-up self-initialise with busy held high
// - Address sets finish within 18.5 microseconds
`timescale 1ns/10ps
`default_nettype none

module char_lcd_instruction_port
  import char_lcd_pkg::*;
#(
  parameter int LONG_CNT = char_lcd_pkg::LONG_CYCLES,
  parameter int EXEC_CNT = char_lcd_pkg::EXEC_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       pinEnable,
  input  wire logic       cmdDataSelect,
  input  wire logic       readNotWrite,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe,
  input  wire logic       ifaceStrapHigh,
  input  wire logic       ifaceStrapLow,
  output logic            busyIndicator,
  output logic      [6:0] addressPointer,
  output logic            busWidthBit,
  output logic            twoLineMode,
  output logic            font5x11,
  output logic      [1:0] dutySelect,
  output logic            displayOn,
  output logic            cursorOn,
  output logic            blinkOn,
  output logic            entryIncrement,
  output logic            entryShift
);

  import char_lcd_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    state_t           state;
    logic [CNT_W-1:0] count;
    logic             eDly;
    logic             nibblePhase;
    logic [3:0]       hiNibble;
    logic [7:0]       commandHoldingReg;
    logic [7:0]       dataHoldingReg;
    logic [6:0]       addressPointer;
    logic             targetGlyph;
    logic             busWidthBit;
    logic             twoLine;
    logic             fontBit;
    logic             displayOn;
    logic             cursorOn;
    logic             blinkOn;
    logic             entryInc;
    logic             entryShift;
    logic             busy;
    logic [6:0]       fillAddr;
    logic [7:0]       dataOut;
  } core_t;

  core_t core_reg;
  core_t core_next;

  logic [7:0] characterRam [CHAR_DEPTH];
  logic [7:0] glyphRam [GLYPH_DEPTH];

  logic       fall;
  logic       byteDone;
  logic       accept;
  logic       parallelIf;
  logic [7:0] byteIn;
  logic [7:0] readByte;
  logic       charWr;
  logic       glyphWr;
  logic [6:0] ramAddr;
  logic [7:0] ramData;

  // ****************************************************************
  // Address stepping with the line map
  // ****************************************************************
  function automatic logic [6:0] stepAddr(input logic [6:0] a, input logic glyph,
                                          input logic two, input logic up);
    logic [6:0] r;
    r = up ? a + 7'h1 : a - 7'h1;
    if (glyph) begin
      r = {1'b0, r[5:0]};
    end else if (two) begin
      if (up && a == LINE1_END) r = LINE2_START;
      else if (up && a == LINE2_END) r = 7'h0;
      else if (!up && a == LINE2_START) r = LINE1_END;
      else if (!up && a == 7'h0) r = LINE2_END;
    end else begin
      if (up && a == ONE_LINE_END) r = 7'h0;
      else if (!up && a == 7'h0) r = ONE_LINE_END;
    end
    return r;
  endfunction

  function automatic logic [7:0] ramRead(input logic [6:0] a, input logic glyph);
    return glyph ? glyphRam[a[5:0]] : characterRam[a];
  endfunction

  // ****************************************************************
  // Host bus
  // ****************************************************************
  // Both straps open selects the parallel bus; serial modes are not built here
  assign parallelIf = !ifaceStrapHigh && !ifaceStrapLow;
  assign fall       = core_reg.eDly && !pinEnable;
  // A byte is complete on one falling edge, or the second of a nibble pair
  assign byteDone   = fall && (core_reg.busWidthBit || core_reg.nibblePhase);
  assign byteIn     = core_reg.busWidthBit ? dataIn : {core_reg.hiNibble, dataIn[7:4]};
  // Status reads never start an operation; everything else is dropped while busy
  assign accept     = byteDone && !core_reg.busy && !(readNotWrite && !cmdDataSelect);
  assign readByte   = cmdDataSelect ? core_reg.dataHoldingReg
                                    : {core_reg.busy, core_reg.addressPointer};
  assign dataOe     = pinEnable && readNotWrite && parallelIf;

  always_comb begin
    logic [6:0] nextAddr;
    logic [6:0] shifted;
    core_next = core_reg;
    nextAddr  = stepAddr(core_reg.addressPointer, core_reg.targetGlyph, core_reg.twoLine,
                         core_reg.entryInc);
    shifted   = stepAddr(core_reg.addressPointer, 1'b0, core_reg.twoLine, byteIn[SH_RL_BIT]);
    charWr    = 1'b0;
    glyphWr   = 1'b0;
    ramAddr   = core_reg.addressPointer;
    ramData   = byteIn;
    core_next.eDly = pinEnable;

    if (fall && !core_reg.busWidthBit) begin
      core_next.nibblePhase = !core_reg.nibblePhase;
      if (!core_reg.nibblePhase) begin
        core_next.hiNibble = dataIn[7:4];
      end
    end

    unique case (core_reg.state)
      ST_FILL: begin
        charWr             = 1'b1;
        ramAddr            = core_reg.fillAddr;
        ramData            = SPACE_CODE;
        core_next.fillAddr = core_reg.fillAddr + 7'h1;
        if (core_reg.fillAddr == ADDR_MAX) begin
          core_next.state = ST_EXEC;
          core_next.count = CNT_W'(LONG_CNT);
        end
      end
      ST_EXEC: begin
        core_next.count = core_reg.count - CNT_W'(1);
        if (core_reg.count <= CNT_W'(1)) begin
          core_next.state = ST_IDLE;
          core_next.busy  = 1'b0;
        end
      end
      ST_IDLE: begin
      end
    endcase

    if (accept) begin
      core_next.busy  = 1'b1;
      core_next.state = ST_EXEC;
      core_next.count = CNT_W'(EXEC_CNT);
      if (!cmdDataSelect) begin
        core_next.commandHoldingReg = byteIn;
        if (byteIn[7]) begin
          core_next.addressPointer = byteIn[6:0];
          core_next.targetGlyph    = 1'b0;
          core_next.dataHoldingReg = ramRead(byteIn[6:0], 1'b0);
        end else if (byteIn[6]) begin
          core_next.addressPointer = {1'b0, byteIn[5:0]};
          core_next.targetGlyph    = 1'b1;
          core_next.dataHoldingReg = ramRead({1'b0, byteIn[5:0]}, 1'b1);
        end else if (byteIn[5]) begin
          core_next.busWidthBit = byteIn[FS_DL_BIT];
          core_next.twoLine     = byteIn[FS_N_BIT];
          core_next.fontBit     = byteIn[FS_F_BIT];
          core_next.nibblePhase = 1'b0;
        end else if (byteIn[4]) begin
          // Display shift leaves the address alone
          if (!byteIn[SH_SC_BIT]) begin
            core_next.addressPointer = shifted;
            core_next.targetGlyph    = 1'b0;
            core_next.dataHoldingReg = ramRead(shifted, 1'b0);
          end
        end else if (byteIn[3]) begin
          core_next.displayOn = byteIn[DC_D_BIT];
          core_next.cursorOn  = byteIn[DC_C_BIT];
          core_next.blinkOn   = byteIn[DC_B_BIT];
        end else if (byteIn[2]) begin
          core_next.entryInc   = byteIn[EM_ID_BIT];
          core_next.entryShift = byteIn[EM_S_BIT];
        end else if (byteIn[1]) begin
          core_next.addressPointer = 7'h0;
          core_next.targetGlyph    = 1'b0;
          core_next.count          = CNT_W'(LONG_CNT);
        end else if (byteIn[0]) begin
          core_next.addressPointer = 7'h0;
          core_next.targetGlyph    = 1'b0;
          core_next.entryInc       = 1'b1;
          core_next.fillAddr       = 7'h0;
          core_next.state          = ST_FILL;
        end
      end else if (!readNotWrite) begin
        // The holding register keeps the written byte, so a read straight
        // after a write returns the byte just written rather than the new location
        core_next.dataHoldingReg = byteIn;
        charWr                   = !core_reg.targetGlyph;
        glyphWr                  = core_reg.targetGlyph;
        core_next.addressPointer = nextAddr;
      end else begin
        // Reads return the byte fetched earlier and fetch the next one; with
        // no address set beforehand the first byte is stale
        core_next.addressPointer = nextAddr;
        core_next.dataHoldingReg = ramRead(nextAddr, core_reg.targetGlyph);
      end
    end

    if (core_reg.busWidthBit) begin
      core_next.dataOut = readByte;
    end else if (!core_next.nibblePhase) begin
      core_next.dataOut = {readByte[7:4], 4'h0};
    end else begin
      core_next.dataOut = {readByte[3:0], 4'h0};
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_reg             <= '0;
      core_reg.state       <= ST_FILL;
      core_reg.busy        <= 1'b1;
      core_reg.busWidthBit <= RST_BUS8;
      core_reg.twoLine     <= RST_TWO;
      core_reg.fontBit     <= RST_FONT;
      core_reg.displayOn   <= RST_DISP;
      core_reg.cursorOn    <= RST_CURSOR;
      core_reg.blinkOn     <= RST_BLINK;
      core_reg.entryInc    <= RST_INC;
      core_reg.entryShift  <= RST_SHIFT;
    end else begin
      core_reg <= core_next;
    end
  end

  // Memories carry no reset; the fill sequence clears the character RAM
  always_ff @(posedge clk_sys) begin
    if (charWr) begin
      characterRam[ramAddr] <= ramData;
    end
    if (glyphWr) begin
      glyphRam[ramAddr[5:0]] <= ramData;
    end
  end

  assign dataOut        = core_reg.dataOut;
  assign busyIndicator  = core_reg.busy;
  assign addressPointer = core_reg.addressPointer;
  assign busWidthBit    = core_reg.busWidthBit;
  assign twoLineMode    = core_reg.twoLine;
  assign font5x11       = core_reg.fontBit && !core_reg.twoLine;
  assign dutySelect     = core_reg.twoLine ? DUTY_1_16 : (core_reg.fontBit ? DUTY_1_11 : DUTY_1_8);
  assign displayOn      = core_reg.displayOn;
  assign cursorOn       = core_reg.cursorOn;
  assign blinkOn        = core_reg.blinkOn;
  assign entryIncrement = core_reg.entryInc;
  assign entryShift     = core_reg.entryShift;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_busyAfterByte;
    @(posedge clk_sys) disable iff (!rst_n)
      accept |=> busyIndicator [*3];
  endproperty
  a_busyAfterByte: assert property (p_busyAfterByte) else $error("busy not raised");

  property p_firstNibbleQuiet;
    @(posedge clk_sys) disable iff (!rst_n)
      (fall && !busWidthBit && !core_reg.nibblePhase && !busyIndicator) |=> !busyIndicator;
  endproperty
  a_firstNibbleQuiet: assert property (p_firstNibbleQuiet) else $error("busy after first nibble");

  property p_funcSet;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && !cmdDataSelect && byteIn[7:5] == 3'b001)
        |=> busWidthBit == $past(byteIn[FS_DL_BIT]) && twoLineMode == $past(byteIn[FS_N_BIT]);
  endproperty
  a_funcSet: assert property (p_funcSet) else $error("function set not applied");

  property p_duty;
    @(posedge clk_sys) disable iff (!rst_n)
      (twoLineMode |-> dutySelect == DUTY_1_16 && !font5x11)
      and (!twoLineMode |-> dutySelect == (font5x11 ? DUTY_1_11 : DUTY_1_8));
  endproperty
  a_duty: assert property (p_duty) else $error("duty mismatch");

  property p_glyphSet;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && !cmdDataSelect && byteIn[7:6] == 2'b01)
        |=> addressPointer == {1'b0, $past(byteIn[5:0])} && core_reg.targetGlyph;
  endproperty
  a_glyphSet: assert property (p_glyphSet) else $error("glyph address not loaded");

  property p_charSet;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && !cmdDataSelect && byteIn[7])
        |=> addressPointer == $past(byteIn[6:0]) && !core_reg.targetGlyph;
  endproperty
  a_charSet: assert property (p_charSet) else $error("char address not loaded");

  property p_glyphTopZero;
    @(posedge clk_sys) disable iff (!rst_n)
      core_reg.targetGlyph |-> !addressPointer[6];
  endproperty
  a_glyphTopZero: assert property (p_glyphTopZero) else $error("glyph address bit 6 set");

  property p_wrapOne;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && cmdDataSelect && !core_reg.targetGlyph && !twoLineMode && entryIncrement
       && addressPointer == ONE_LINE_END) |=> addressPointer == 7'h0;
  endproperty
  a_wrapOne: assert property (p_wrapOne) else $error("one-line wrap wrong");

  property p_wrapTwo;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && cmdDataSelect && !core_reg.targetGlyph && twoLineMode && entryIncrement
       && addressPointer == LINE1_END) |=> addressPointer == LINE2_START;
  endproperty
  a_wrapTwo: assert property (p_wrapTwo) else $error("line two jump wrong");

  property p_status;
    @(posedge clk_sys) disable iff (!rst_n)
      (pinEnable && readNotWrite && !cmdDataSelect && busWidthBit && !fall)
        |=> dataOut == {$past(busyIndicator), $past(addressPointer)};
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");

  property p_drive;
    @(posedge clk_sys) disable iff (!rst_n)
      dataOe == (pinEnable && readNotWrite && parallelIf);
  endproperty
  a_drive: assert property (p_drive) else $error("bus driven outside read");

  property p_stepWrite;
    @(posedge clk_sys) disable iff (!rst_n)
      (accept && cmdDataSelect && !readNotWrite)
        |=> addressPointer == $past(stepAddr(addressPointer, core_reg.targetGlyph, twoLineMode,
                                             entryIncrement));
  endproperty
  a_stepWrite: assert property (p_stepWrite) else $error("write step wrong");

  property p_fillBusy;
    @(posedge clk_sys) disable iff (!rst_n)
      core_reg.state == ST_FILL |-> busyIndicator;
  endproperty
  a_fillBusy: assert property (p_fillBusy) else $error("ready during init");

  c_nibbleWrite: cover property (@(posedge clk_sys) disable iff (!rst_n)
    accept && !busWidthBit && !readNotWrite);
  c_dataRead: cover property (@(posedge clk_sys) disable iff (!rst_n)
    accept && cmdDataSelect && readNotWrite);
  c_cursorShift: cover property (@(posedge clk_sys) disable iff (!rst_n)
    accept && !cmdDataSelect && byteIn[7:3] == 5'b00010);
  c_ready: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(busyIndicator));

endmodule // char_lcd_instruction_port

`default_nettype wire

// ==== bench/lcd_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module lcd_host_model #(
  parameter int MARGIN = 2
) (
  input  wire logic       clk_sys,
  output logic            pinEnable,
  output logic            cmdDataSelect,
  output logic            readNotWrite,
  output logic      [7:0] dataIn,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe
);
  logic nibbleMode;
  logic oeSeen;

  initial begin
    pinEnable     = 1'b0;
    cmdDataSelect = 1'b0;
    readNotWrite  = 1'b0;
    dataIn        = 8'h00;
    nibbleMode    = 1'b0;
    oeSeen        = 1'b0;
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Lines not driven by us carry the inverse of the last value, so stale data never looks valid
  task automatic pulse(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    pinEnable     <= 1'b1;
    cmdDataSelect <= rs;
    readNotWrite  <= rw;
    dataIn        <= rw ? ~dataIn : d;
    repeat (2) @(posedge clk_sys);
    // Read back away from the edge that updates the registered output
    @(negedge clk_sys);
    q = dataOut;
    oeSeen = dataOe;
    @(posedge clk_sys);
    pinEnable <= 1'b0;
    @(posedge clk_sys);
    dataIn <= ~dataIn;
  endtask

  task automatic xfer(input logic rs, input logic rw, input logic [7:0] b, output logic [7:0] q);
    logic [7:0] h;
    logic [7:0] l;
    if (nibbleMode) begin
      pulse(rs, rw, {b[7:4], ~b[7:4]}, h);
      pulse(rs, rw, {b[3:0], ~b[3:0]}, l);
      q = {h[7:4], l[7:4]};
    end else begin
      pulse(rs, rw, b, q);
    end
  endtask

  task automatic waitReady();
    logic [7:0] s;
    int n;
    s = 8'h80;
    n = 0;
    while (s[7] !== 1'b0 && n < 400) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      n++;
    end
    repeat (MARGIN) @(posedge clk_sys);
  endtask

  task automatic send(input logic rs, input logic [7:0] b);
    logic [7:0] q;
    waitReady();
    xfer(rs, 1'b0, b, q);
  endtask

  task automatic fetch(output logic [7:0] q);
    waitReady();
    xfer(1'b1, 1'b1, 8'h00, q);
  endtask
endmodule // lcd_host_model

`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb;
  import char_lcd_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        pinEnable, cmdDataSelect, readNotWrite, dataOe, busyIndicator;
  logic [7:0]  dataIn, dataOut, q;
  logic        ifaceStrapHigh = 1'b0;
  logic        ifaceStrapLow = 1'b0;
  logic [6:0]  addressPointer;
  logic        busWidthBit, twoLineMode, font5x11, displayOn, cursorOn, blinkOn, entryIncrement, entryShift;
  logic [1:0]  dutySelect;
  logic [16:0] st;
  int          badCount = 0;
  int          nChecks = 0;
  int          n;
  logic [7:0]  rowCmd [16] = '{8'h38, 8'h34, 8'h3c, 8'h30, 8'h0f, 8'h08, 8'h07, 8'h06, 8'h7f, 8'hc5, 8'h14, 8'h10,
                               8'h18, 8'h02, 8'h04, 8'h01};
  logic [16:0] rowExp [16] = '{17'h1a100, 17'h15100, 17'h1a100, 17'h10100, 17'h10f00, 17'h10100,
                               17'h10180, 17'h10100, 17'h1013f, 17'h10145, 17'h10146, 17'h10145,
                               17'h10145, 17'h10100, 17'h10000, 17'h10100};

  assign st = {busWidthBit, twoLineMode, font5x11, dutySelect, displayOn, cursorOn, blinkOn,
               entryIncrement, entryShift, addressPointer};

  always #2.5 clk_sys = ~clk_sys;

  char_lcd_instruction_port #(.LONG_CNT(40), .EXEC_CNT(8)) char_lcd_instruction_port_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .pinEnable(pinEnable), .cmdDataSelect(cmdDataSelect),
    .readNotWrite(readNotWrite), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .ifaceStrapHigh(ifaceStrapHigh), .ifaceStrapLow(ifaceStrapLow), .busyIndicator(busyIndicator),
    .addressPointer(addressPointer), .busWidthBit(busWidthBit), .twoLineMode(twoLineMode),
    .font5x11(font5x11), .dutySelect(dutySelect), .displayOn(displayOn), .cursorOn(cursorOn),
    .blinkOn(blinkOn), .entryIncrement(entryIncrement), .entryShift(entryShift));

  lcd_host_model host_i (
    .clk_sys(clk_sys), .pinEnable(pinEnable), .cmdDataSelect(cmdDataSelect),
    .readNotWrite(readNotWrite), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));

  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string msg);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk_sys);
    check(st, 17'h10100, "reset state");
    check({16'h0, busyIndicator}, 17'h1, "busy in reset");
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      host_i.send(1'b0, rowCmd[i]);
      host_i.waitReady();
      check(st, rowExp[i], "command row");
      host_i.xfer(1'b0, 1'b1, 8'h00, q);
      check({9'h0, q}, {10'h0, rowExp[i][6:0]}, "status read");
    end
    host_i.send(1'b0, 8'h80);
    host_i.send(1'b1, 8'h41);
    host_i.send(1'b1, 8'h42);
    host_i.waitReady();
    check({10'h0, addressPointer}, 17'h2, "address after writes");
    host_i.fetch(q);
    check({9'h0, q}, 17'h42, "read after write");
    host_i.send(1'b0, 8'h80);
    host_i.fetch(q);
    check({9'h0, q}, 17'h41, "first read");
    host_i.fetch(q);
    check({9'h0, q}, 17'h42, "second read");
    host_i.send(1'b0, 8'h04);
    host_i.send(1'b0, 8'h81);
    host_i.fetch(q);
    host_i.waitReady();
    check({1'b0, q, addressPointer, 1'b0}, {1'b0, 8'h42, 7'h00, 1'b0}, "decrement read");
    host_i.send(1'b0, 8'h06);
    host_i.send(1'b0, 8'h80);
    host_i.send(1'b0, 8'h14);
    host_i.fetch(q);
    check({9'h0, q}, 17'h42, "cursor shift prefetch");
    host_i.send(1'b0, 8'h40);
    host_i.send(1'b1, 8'haa);
    host_i.send(1'b0, 8'h40);
    host_i.fetch(q);
    check({9'h0, q}, 17'haa, "glyph data");
    host_i.send(1'b0, 8'h90);
    host_i.fetch(q);
    check({9'h0, q}, 17'h20, "cleared character");
    host_i.send(1'b0, 8'hcf);
    host_i.send(1'b1, 8'h55);
    host_i.waitReady();
    check({10'h0, addressPointer}, 17'h0, "one-line wrap");
    host_i.send(1'b0, 8'h38);
    host_i.send(1'b0, 8'ha7);
    host_i.send(1'b1, 8'h55);
    host_i.waitReady();
    check({10'h0, addressPointer}, 17'h40, "two-line wrap");
    // Second command lands while busy and must leave no trace
    host_i.xfer(1'b0, 1'b0, 8'h85, q);
    host_i.xfer(1'b0, 1'b0, 8'h86, q);
    n = 0;
    while (busyIndicator !== 1'b0 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    check({16'h0, n <= 8}, 17'h1, "address set duration");
    check({10'h0, addressPointer}, 17'h5, "busy refusal");
    host_i.send(1'b0, 8'h20);
    // The host follows the width change at once, so its polls pair up
    host_i.nibbleMode = 1'b1;
    host_i.waitReady();
    check({16'h0, busWidthBit}, 17'h0, "nibble select");
    host_i.pulse(1'b0, 1'b0, 8'h87, q);
    repeat (2) @(posedge clk_sys);
    #1;
    check({16'h0, busyIndicator}, 17'h0, "busy after first nibble");
    host_i.pulse(1'b0, 1'b0, 8'h5a, q);
    repeat (2) @(posedge clk_sys);
    #1;
    check({16'h0, busyIndicator}, 17'h1, "busy after second nibble");
    host_i.waitReady();
    host_i.xfer(1'b0, 1'b1, 8'h00, q);
    check({8'h0, host_i.oeSeen, q}, 17'h105, "nibble status");
    host_i.send(1'b1, 8'hc3);
    check({16'h0, host_i.oeSeen}, 17'h0, "no drive on write");
    host_i.send(1'b0, 8'h85);
    host_i.fetch(q);
    check({9'h0, q}, 17'hc3, "nibble data");
    host_i.send(1'b0, 8'h30);
    host_i.nibbleMode = 1'b0;
    host_i.waitReady();
    check({16'h0, busWidthBit}, 17'h1, "byte select");
    @(posedge clk_sys);
    ifaceStrapHigh <= 1'b1;
    host_i.pulse(1'b0, 1'b1, 8'h00, q);
    check({16'h0, host_i.oeSeen}, 17'h0, "strapped no drive");
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    badCount++;
    summarize();
  end
endmodule // tb

`default_nettype wire
